// file: psitc_consts.svh
`ifndef PSITC_CONSTS_SVH
`define PSITC_CONSTS_SVH

// ****************************************************************
// command codes and pages
// ****************************************************************
`define PSITC_CMD_INPUT      8'h7c
`define PSITC_CMD_TEMP       8'h7d
`define PSITC_CMD_CML        8'h7e
`define PSITC_PAGE_A         8'h00
`define PSITC_PAGE_B         8'h01
`define PSITC_PAGE_ALL       8'hff

// ****************************************************************
// supported-bit masks and reset values
// ****************************************************************
`define PSITC_INPUT_MASK     8'h9f
`define PSITC_TEMP_MASK      8'hc0
`define PSITC_CML_MASK       8'hea
`define PSITC_STATUS_RESET   8'h00

// ****************************************************************
// bit positions
// ****************************************************************
`define PSITC_BIT_BAD_CMD    7
`define PSITC_BIT_BAD_DATA   6

// ****************************************************************
// host wishbone map and fields
// ****************************************************************
`define PSITC_WB_CMD_REG     8'h00
`define PSITC_WB_STAT_REG    8'h04
`define PSITC_FLD_WE         24
`define PSITC_FLD_GO         25
`define PSITC_FLD_CMD        0
`define PSITC_FLD_PAGE       8
`define PSITC_FLD_WDATA      16
`define PSITC_FLD_BUSY       0
`define PSITC_FLD_DONE       1
`define PSITC_FLD_RD_LO      8

`endif

// file: psitc_pkg.sv
package psitc_pkg;

    typedef enum logic [1:0] {
        PSITC_IDLE = 2'h0,
        PSITC_REQ  = 2'h1
    } psitc_host_e;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
        logic [7:0] inp;
        logic [7:0] temp_a;
        logic [7:0] temp_b;
        logic [7:0] cml;
    } psitc_dev_s;

    typedef struct packed {
        psitc_host_e state;
        logic        req;
        logic        we;
        logic [7:0]  cmd;
        logic [7:0]  page;
        logic [7:0]  wdata;
        logic        done;
        logic [7:0]  last_rd;
        logic        wb_ack;
        logic [31:0] wb_dat;
    } psitc_host_s;

endpackage

// file: psitc_if.sv
`timescale 1ns/10ps

interface psitc_if;
    logic       req;
    logic       we;
    logic [7:0] cmd;
    logic [7:0] page;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;

    modport dev (
        input  req,
        input  we,
        input  cmd,
        input  page,
        input  wdata,
        output ack,
        output rdata
    );

    modport host (
        output req,
        output we,
        output cmd,
        output page,
        output wdata,
        input  ack,
        input  rdata
    );
endinterface

// file: psitc_dev.sv
`timescale 1ns/10ps
`include "psitc_consts.svh"

module psitc_dev (
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rstn_in,
    // link to the host
    psitc_if.dev            link,
    // detector event pulses, one per bit position
    input  wire logic [7:0] input_event_in,
    input  wire logic [7:0] temp_a_event_in,
    input  wire logic [7:0] temp_b_event_in,
    input  wire logic [7:0] cml_event_in,
    // latched status, for local fault pins
    output logic      [7:0] input_status_out,
    output logic      [7:0] temp_a_status_out,
    output logic      [7:0] temp_b_status_out,
    output logic      [7:0] cml_status_out
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // masking both terms keeps unsupported and reserved bits at zero
    function automatic logic [7:0] flag_update(
        input logic [7:0] cur,
        input logic [7:0] clr,
        input logic [7:0] ev,
        input logic [7:0] mask
    );
        flag_update = ((cur & ~clr) | ev) & mask;
    endfunction

    function automatic logic is_page_b(input logic [7:0] page);
        is_page_b = (page == `PSITC_PAGE_B);
    endfunction

    function automatic logic is_page_a(input logic [7:0] page);
        is_page_a = (page == `PSITC_PAGE_A) || (page == `PSITC_PAGE_ALL);
    endfunction

    function automatic logic is_page_all(input logic [7:0] page);
        is_page_all = (page == `PSITC_PAGE_ALL);
    endfunction

    // a write of zeros leaves every flag alone; reads clear nothing
    function automatic logic [7:0] clear_bits(
        input logic       hit,
        input logic       we,
        input logic [7:0] wdata
    );
        clear_bits = `PSITC_STATUS_RESET;
        if (hit && we) begin
            clear_bits = wdata;
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    psitc_pkg::psitc_dev_s st;
    psitc_pkg::psitc_dev_s next_st;

    logic       take;
    logic [7:0] rd;
    logic [7:0] clr_in;
    logic [7:0] clr_ta;
    logic [7:0] clr_tb;
    logic [7:0] clr_cml;
    logic       bad_cmd;
    logic       bad_data;
    logic [7:0] own_cml_ev;
    // byte selected by the request being taken
    logic       hit_inp;
    logic       hit_ta;
    logic       hit_tb;
    logic       hit_cml;

    // ****************************************************************
    // transaction decode and flag update
    // ****************************************************************
    always_comb begin
        next_st  = st;
        take     = link.req && !st.ack;
        rd       = `PSITC_STATUS_RESET;
        hit_inp  = 1'b0;
        hit_ta   = 1'b0;
        hit_tb   = 1'b0;
        hit_cml  = 1'b0;
        bad_cmd  = 1'b0;
        bad_data = 1'b0;

        // one byte per request, acked for one cycle; a request still held after the ack is taken again
        next_st.ack = take;

        // ****************************************************************
        // byte select
        // ****************************************************************
        if (!take) begin
            // no request: nothing selected
        end else if (link.cmd == `PSITC_CMD_INPUT) begin
            // no page term: one byte for both channels
            hit_inp = 1'b1;
        end else if (link.cmd == `PSITC_CMD_TEMP) begin
            hit_ta   = is_page_a(link.page);
            hit_tb   = is_page_b(link.page);
            // unknown page: no thermal byte touched, reads zero; bad-data flag set
            bad_data = !hit_ta && !hit_tb;
        end else if (link.cmd == `PSITC_CMD_CML) begin
            // shared like the input byte
            hit_cml = 1'b1;
        end else begin
            bad_cmd = 1'b1;
        end

        // ****************************************************************
        // read mux
        // ****************************************************************
        // page all reads channel A
        if (hit_inp) begin
            rd = st.inp;
        end else if (hit_ta) begin
            rd = st.temp_a;
        end else if (hit_tb) begin
            rd = st.temp_b;
        end else if (hit_cml) begin
            rd = st.cml;
        end
        // the byte stands until the next request is taken
        if (take) begin
            next_st.rdata = rd;
        end

        // ****************************************************************
        // write decode
        // ****************************************************************
        // page all clears both channels
        clr_in  = clear_bits(hit_inp, link.we, link.wdata);
        clr_ta  = clear_bits(hit_ta, link.we, link.wdata);
        clr_tb  = clear_bits(hit_tb || (hit_ta && is_page_all(link.page)),
                             link.we, link.wdata);
        clr_cml = clear_bits(hit_cml, link.we, link.wdata);

        // ****************************************************************
        // flag update
        // ****************************************************************
        // set beats clear, so a fault seen during a clearing write stays
        own_cml_ev = `PSITC_STATUS_RESET;
        own_cml_ev[`PSITC_BIT_BAD_CMD]  = bad_cmd;
        own_cml_ev[`PSITC_BIT_BAD_DATA] = bad_data;

        next_st.inp = flag_update(st.inp, clr_in, input_event_in,
                                  `PSITC_INPUT_MASK);
        next_st.temp_a = flag_update(st.temp_a, clr_ta, temp_a_event_in,
                                     `PSITC_TEMP_MASK);
        next_st.temp_b = flag_update(st.temp_b, clr_tb, temp_b_event_in,
                                     `PSITC_TEMP_MASK);
        next_st.cml = flag_update(st.cml, clr_cml,
                                  cml_event_in | own_cml_ev,
                                  `PSITC_CML_MASK);
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign link.ack          = st.ack;
    assign link.rdata        = st.rdata;
    assign input_status_out  = st.inp;
    assign temp_a_status_out = st.temp_a;
    assign temp_b_status_out = st.temp_b;
    assign cml_status_out    = st.cml;

endmodule

// file: psitc_host.sv
`timescale 1ns/10ps
`include "psitc_consts.svh"

module psitc_host (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    // wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // link to the device
    psitc_if.host            link
);

    psitc_pkg::psitc_host_s st;
    psitc_pkg::psitc_host_s next_st;

    logic        wb_take;
    logic [31:0] cmd_word;
    logic [31:0] stat_word;

    // ****************************************************************
    // wishbone slave and link sequencer
    // ****************************************************************
    always_comb begin
        next_st   = st;
        wb_take   = wb_cyc_in && wb_stb_in && !st.wb_ack;
        cmd_word  = 32'h0000_0000;
        cmd_word[`PSITC_FLD_CMD +: 8]    = st.cmd;
        cmd_word[`PSITC_FLD_PAGE +: 8]   = st.page;
        cmd_word[`PSITC_FLD_WDATA +: 8]  = st.wdata;
        cmd_word[`PSITC_FLD_WE]          = st.we;
        stat_word = 32'h0000_0000;
        stat_word[`PSITC_FLD_BUSY]       = st.state == psitc_pkg::PSITC_REQ;
        stat_word[`PSITC_FLD_DONE]       = st.done;
        stat_word[`PSITC_FLD_RD_LO +: 8] = st.last_rd;
        next_st.wb_ack = wb_take;

        if (wb_take) begin
            next_st.wb_dat = 32'h0000_0000;
            if (wb_adr_in == `PSITC_WB_CMD_REG) begin
                next_st.wb_dat = cmd_word;
            end else if (wb_adr_in == `PSITC_WB_STAT_REG) begin
                next_st.wb_dat = stat_word;
            end
        end

        // command fields are frozen while a byte is in flight
        if (wb_take && wb_we_in && wb_adr_in == `PSITC_WB_CMD_REG
            && st.state == psitc_pkg::PSITC_IDLE) begin
            if (wb_sel_in[0]) begin
                next_st.cmd = wb_dat_in[`PSITC_FLD_CMD +: 8];
            end
            if (wb_sel_in[1]) begin
                next_st.page = wb_dat_in[`PSITC_FLD_PAGE +: 8];
            end
            if (wb_sel_in[2]) begin
                next_st.wdata = wb_dat_in[`PSITC_FLD_WDATA +: 8];
            end
            if (wb_sel_in[3]) begin
                next_st.we = wb_dat_in[`PSITC_FLD_WE];
                if (wb_dat_in[`PSITC_FLD_GO]) begin
                    next_st.state = psitc_pkg::PSITC_REQ;
                    next_st.req   = 1'b1;
                    next_st.done  = 1'b0;
                end
            end
        end

        case (st.state)
            psitc_pkg::PSITC_REQ: begin
                // hold one byte request until the device answers
                if (link.ack) begin
                    next_st.req   = 1'b0;
                    next_st.state = psitc_pkg::PSITC_IDLE;
                    next_st.done  = 1'b1;
                    if (!st.we) begin
                        next_st.last_rd = link.rdata;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // a clear is a write of ones to the flags; page picks the channel
    assign link.req    = st.req;
    assign link.we     = st.we;
    assign link.cmd    = st.cmd;
    assign link.page   = st.page;
    assign link.wdata  = st.wdata;
    assign wb_ack_out  = st.wb_ack;
    assign wb_dat_out  = st.wb_dat;

endmodule

// file: psitc_monitor.sv
`timescale 1ns/10ps
// ****************
// link checker
// ****************
module psitc_monitor (
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rstn_in,
    // link signals
    input  wire logic       req,
    input  wire logic       we,
    input  wire logic [7:0] cmd,
    input  wire logic [7:0] page,
    input  wire logic [7:0] wdata,
    input  wire logic       ack,
    input  wire logic [7:0] rdata
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    logic rd;
    assign rd = ack && !we;

    property p_ack_next;
        req && !ack |=> ack;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("link answer late");
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("link answer too long");
    property p_no_spur;
        !req |=> !ack;
    endproperty
    a_no_spur: assert property (p_no_spur)
        else $error("link answer without request");
    property p_req_hold;
        req && !ack |=> req && $stable({we, cmd, page, wdata});
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request changed before answer");
    property p_req_drop;
        ack |=> !req;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("request held after answer");
    property p_inp_zero;
        rd && cmd == 8'h7c |-> rdata[6:5] == 2'h0;
    endproperty
    a_inp_zero: assert property (p_inp_zero)
        else $error("input byte unused bits set");
    property p_tmp_zero;
        rd && cmd == 8'h7d |-> rdata[5:0] == 6'h00;
    endproperty
    a_tmp_zero: assert property (p_tmp_zero)
        else $error("thermal byte unused bits set");
    property p_cml_zero;
        rd && cmd == 8'h7e |-> (rdata & 8'h15) == 8'h00;
    endproperty
    a_cml_zero: assert property (p_cml_zero)
        else $error("comm byte unused bits set");
    property p_bad_cmd;
        rd && !(cmd inside {8'h7c, 8'h7d, 8'h7e}) |-> rdata == 8'h00;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd)
        else $error("unknown command returned data");
    property p_bad_page;
        rd && cmd == 8'h7d && !(page inside {8'h00, 8'h01, 8'hff})
            |-> rdata == 8'h00;
    endproperty
    a_bad_page: assert property (p_bad_page)
        else $error("bad page returned data");
    property p_rd_hold;
        !ack |-> $stable(rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read byte moved between answers");
endmodule

// file: pmbus_status_input_temp_cml_tb.sv
`timescale 1ns/10ps
`include "psitc_consts.svh"
module pmbus_status_input_temp_cml_tb;
    logic        core_clk_in, rstn_in, cyc, stb, we_w, wack;
    logic [7:0]  adr, ev_in, ev_ta, ev_tb, ev_cml, st_in, st_ta, st_tb, st_cml;
    logic [7:0]  e_in, e_ta, e_tb, e_cml;
    logic [3:0]  sel;
    logic [31:0] dw, dr, r, rn;
    logic [7:0]  q[$];
    logic [7:0]  cmds[4] = '{8'h7c, 8'h7d, 8'h7e, 8'h7f};
    logic [7:0]  pgs[4] = '{8'h00, 8'h01, 8'hff, 8'h02};
    integer      seed = 32'hdef8554e;
    int          failures = 0, checks = 0;

    psitc_if i_psitc_if ();
    psitc_dev i_psitc_dev (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .link(i_psitc_if), .input_event_in(ev_in), .temp_a_event_in(ev_ta),
        .temp_b_event_in(ev_tb), .cml_event_in(ev_cml),
        .input_status_out(st_in), .temp_a_status_out(st_ta),
        .temp_b_status_out(st_tb), .cml_status_out(st_cml));
    psitc_host i_psitc_host (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we_w), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(dw), .wb_dat_out(dr), .wb_ack_out(wack),
        .link(i_psitc_if));
    psitc_monitor i_psitc_monitor (.core_clk_in(core_clk_in),
        .rstn_in(rstn_in), .req(i_psitc_if.req), .we(i_psitc_if.we),
        .cmd(i_psitc_if.cmd), .page(i_psitc_if.page),
        .wdata(i_psitc_if.wdata), .ack(i_psitc_if.ack),
        .rdata(i_psitc_if.rdata));

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string n, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ce lands on the edge where the device takes the request
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [7:0] ce);
        int n;
        @(posedge core_clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we_w <= w;
        adr <= a;
        dw <= d;
        for (n = 0; n < 50 && wack !== 1'b1; n++) begin
            @(posedge core_clk_in);
            if (n == 0) ev_in <= ce;
        end
        if (n == 50) failures++;
        r = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        ev_in <= 8'h00;
    endtask

    task automatic pulse(input logic [31:0] v);
        @(posedge core_clk_in);
        {ev_cml, ev_tb, ev_ta, ev_in} <= v;
        e_in |= v[7:0] & `PSITC_INPUT_MASK;
        e_ta |= v[15:8] & `PSITC_TEMP_MASK;
        e_tb |= v[23:16] & `PSITC_TEMP_MASK;
        e_cml |= v[31:24] & `PSITC_CML_MASK;
        @(posedge core_clk_in);
        {ev_cml, ev_tb, ev_ta, ev_in} <= 32'h0;
    endtask

    task automatic op(input logic w, input logic [7:0] c, p, d, ce);
        logic [7:0] x;
        logic       bad;
        int         n;
        bad = c == 8'h7d && !(p inside {8'h00, 8'h01, 8'hff});
        x = 8'h00;
        if (c == 8'h7c) x = e_in;
        if (c == 8'h7e) x = e_cml;
        if (c == 8'h7d && !bad) x = p == 8'h01 ? e_tb : e_ta;
        if (!w) q.push_back(x);
        wb(1'b1, 8'h00, {7'h01, w, d, p, c}, ce);
        if (w && c == 8'h7c) e_in &= ~d;
        if (w && c == 8'h7d && !bad && p != 8'h01) e_ta &= ~d;
        if (w && c == 8'h7d && !bad && p != 8'h00) e_tb &= ~d;
        if (w && c == 8'h7e) e_cml &= ~d;
        e_in |= ce & `PSITC_INPUT_MASK;
        if (!(c inside {8'h7c, 8'h7d, 8'h7e})) e_cml[7] = 1'b1;
        if (bad) e_cml[6] = 1'b1;
        for (n = 0; n < 20; n++) begin
            wb(1'b0, 8'h04, 32'h0, 8'h00);
            if (r[1] === 1'b1) break;
        end
        if (n == 20) failures++;
        if (!w) chk("last", x, r[15:8]);
    endtask

    task automatic chk_all();
        chk("inp", e_in, st_in);
        chk("tmp_a", e_ta, st_ta);
        chk("tmp_b", e_tb, st_tb);
        chk("cml", e_cml, st_cml);
    endtask

    // ****************
    // stimulus and observer
    // ****************
    always @(posedge core_clk_in) begin
        if (rstn_in && i_psitc_if.ack === 1'b1 && i_psitc_if.we === 1'b0)
            chk("rdata", q.pop_front(), i_psitc_if.rdata);
    end

    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    initial begin
        #1000000;
        failures++;
        report_and_stop();
    end

    initial begin
        {rstn_in, cyc, stb, we_w, adr, dw} <= '0;
        {ev_cml, ev_tb, ev_ta, ev_in} <= 32'h0;
        {e_in, e_ta, e_tb, e_cml} = 32'h0;
        sel <= 4'hf;
        repeat (10) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        @(posedge core_clk_in);
        chk_all();
        // unmapped write must not launch a link transfer
        wb(1'b1, 8'h08, 32'hffffffff, 8'h00);
        wb(1'b0, 8'h08, 32'h0, 8'h00);
        chk("unmap", 8'h00, r[7:0] | r[15:8] | r[23:16] | r[31:24]);
        wb(1'b0, 8'h04, 32'h0, 8'h00);
        chk("idle", 8'h00, r[7:0]);
        for (int i = 0; i < 64; i++) begin
            rn = $random(seed);
            pulse($random(seed));
            op(i[4], cmds[i[1:0]], pgs[i[3:2]], rn[7:0], rn[15:8]);
            chk_all();
        end
        for (int i = 0; i < 3; i++) begin
            op(1'b1, cmds[i], 8'hff, 8'hff, 8'h00);
        end
        chk_all();
        rstn_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        {e_in, e_ta, e_tb, e_cml} = 32'h0;
        @(posedge core_clk_in);
        chk_all();
        report_and_stop();
    end
endmodule
